/* File: hmap_pkg.sv */
// Constants and types of the host memory access port.
// Assumes one 50 MHz processor clock and an asynchronous host on the pins.
package hmap_pkg;
  localparam int DW      = 16;
  localparam int AW      = 14;
  localparam int MEM_AW  = 8;
  localparam int SRO_BIT = 14;
  localparam logic [AW-1:0] OVL_ADDR  = 14'h3fe7;
  localparam logic [DW-1:0] OVL_RESET = 16'h0000;
  localparam logic [DW-1:0] DATA_ZERO = 16'h0000;
  localparam logic [AW-1:0] ADDR_ZERO = 14'h0000;
  localparam logic [AW-1:0] ADDR_ONE  = 14'h0001;
  // Clock period in ns and least write busy time in tenths of a clock period.
  localparam int CLK_PERIOD_NS    = 20;
  localparam int ACK_MIN_TCK_X10  = 15;
  localparam int ACK_MIN_CYC      = (ACK_MIN_TCK_X10 + 9) / 10;
  localparam int CNT_W            = 2;
  localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 2'h1;
  localparam logic [CNT_W-1:0] CNT_MIN  = CNT_W'(ACK_MIN_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_MAX  = 2'h3;
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } hmap_word_s;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WR_BUSY = 3'b001,
    ST_WR_PUSH = 3'b010,
    ST_WR_LONG = 3'b011,
    ST_RD_BUSY = 3'b100,
    ST_RD_END  = 3'b101
  } hmap_state_e;
endpackage

/* File: hmap_port.sv */
// Host memory access port: host writes and reads internal memory over a
// multiplexed 16-bit bus with select, strobes and a busy/acknowledge line.
// Assumes the address pointer is loaded by the core; pins are asynchronous.
//
// Contract
// - Acknowledge goes high without waiting for a clock once a write starts.
// - On a write acknowledge stays high at least one and a half clock periods.
// - A write that ends before acknowledge falls takes the data seen at its end.
// - A write held past acknowledge low takes the data seen at its end after ready.
// - Acknowledge goes high once a read starts, while the write buffer drains.
// - A read drives the previously fetched word and keeps it until the read ends.
// - The bus is released as soon as the read ends.
// - Bit 14 of the overlay control register turns the short read only mode on.
// - Reset clears the short read only bit.
// - Both the core and the host can write the overlay control register.
`timescale 1ns/1ps
module hmap_port (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  // Host pins
  input  wire logic                    host_select_n,
  input  wire logic                    host_read_strobe_n,
  input  wire logic                    host_write_strobe_n,
  output logic                         host_ack_n,
  input  wire logic [hmap_pkg::DW-1:0] host_addr_data_bus_i,
  output logic [hmap_pkg::DW-1:0]      host_addr_data_bus_o,
  output logic                         host_addr_data_bus_oe,
  // Core side
  input  wire logic                    core_mem_busy,
  input  wire logic                    core_addr_we,
  input  wire logic [hmap_pkg::AW-1:0] core_addr,
  input  wire logic                    core_ovl_we,
  input  wire logic [hmap_pkg::DW-1:0] core_ovl_data,
  // Status
  output logic [hmap_pkg::DW-1:0]      port_overlay_control,
  output logic                         short_read_only
);
  // Pin synchronisers: select, read, write, then the bus.
  logic [hmap_pkg::DW+2:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_q <= 19'h7_0000;
      pin_s2_q <= 19'h7_0000;
    end else begin
      pin_s1_q <= {host_select_n, host_read_strobe_n, host_write_strobe_n,
                   host_addr_data_bus_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic                    acc_wr_s, acc_rd_s, acc_raw, acc_rd_raw;
  logic [hmap_pkg::DW-1:0] data_s;
  assign acc_wr_s   = ~pin_s2_q[18] & ~pin_s2_q[16];
  assign acc_rd_s   = ~pin_s2_q[18] & ~pin_s2_q[17];
  assign data_s     = pin_s2_q[hmap_pkg::DW-1:0];
  assign acc_rd_raw = ~host_select_n & ~host_read_strobe_n;
  assign acc_raw    = acc_rd_raw | (~host_select_n & ~host_write_strobe_n);

  // Two-entry write buffer toward memory.
  hmap_pkg::hmap_word_s buf_q [hmap_pkg::BUF_DEPTH];
  hmap_pkg::hmap_word_s in_word;
  logic       in_valid, in_ready, out_valid, out_ready;
  logic       wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  // The core owns memory while busy, so draining stalls and the buffer fills.
  assign out_ready = ~core_mem_busy & ~core_ovl_we;

  always_comb begin
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (in_valid && in_ready) begin
      wp_d  = ~wp_q;
      cnt_d = cnt_d + 2'h1;
    end
    if (out_valid && out_ready) begin
      rp_d  = ~rp_q;
      cnt_d = cnt_d - 2'h1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (in_valid && in_ready) begin
      buf_q[wp_q] <= in_word;
    end
  end

  // Memory and overlay register.
  logic [hmap_pkg::DW-1:0] mem_q [2**hmap_pkg::MEM_AW];
  logic [hmap_pkg::DW-1:0] ovl_q, ovl_d;
  logic                    drain, drain_ovl;
  hmap_pkg::hmap_word_s    out_word;
  assign out_word  = buf_q[rp_q];
  assign drain     = out_valid & out_ready;
  assign drain_ovl = drain & (out_word.addr == hmap_pkg::OVL_ADDR);

  always_ff @(posedge mclk) begin
    if (drain && !drain_ovl) begin
      mem_q[out_word.addr[hmap_pkg::MEM_AW-1:0]] <= out_word.data;
    end
  end

  always_comb begin
    ovl_d = ovl_q;
    if (core_ovl_we) begin
      ovl_d = core_ovl_data;
    end else if (drain_ovl) begin
      ovl_d = out_word.data;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ovl_q <= hmap_pkg::OVL_RESET;
    end else begin
      ovl_q <= ovl_d;
    end
  end
  assign port_overlay_control = ovl_q;
  assign short_read_only = ovl_q[hmap_pkg::SRO_BIT];

  // Transfer sequencer.
  hmap_pkg::hmap_state_e        st_q, st_d;
  logic [hmap_pkg::CNT_W-1:0]   tm_q, tm_d;
  logic [hmap_pkg::AW-1:0]      addr_q, addr_d, addr_nx;
  logic [hmap_pkg::DW-1:0]      last_q, last_d, prev_q, prev_d;
  logic                         busy_q, busy_d, taken, fetch, min_ok;
  assign addr_nx = addr_q + hmap_pkg::ADDR_ONE;
  assign min_ok  = (tm_q >= hmap_pkg::CNT_MIN);
  assign taken   = (st_q != hmap_pkg::ST_IDLE);
  assign in_word = '{addr: addr_q, data: last_q};

  always_comb begin
    st_d     = st_q;
    tm_d     = (tm_q == hmap_pkg::CNT_MAX) ? tm_q : tm_q + hmap_pkg::CNT_ONE;
    addr_d   = addr_q;
    last_d   = acc_wr_s ? data_s : last_q;
    busy_d   = busy_q;
    in_valid = 1'b0;
    fetch    = 1'b0;
    unique case (st_q)
      hmap_pkg::ST_IDLE: begin
        tm_d = hmap_pkg::CNT_ZERO;
        if (acc_wr_s) begin
          st_d   = hmap_pkg::ST_WR_BUSY;
          busy_d = 1'b1;
        end else if (acc_rd_s) begin
          st_d   = hmap_pkg::ST_RD_BUSY;
          busy_d = 1'b1;
        end else if (core_addr_we) begin
          addr_d = core_addr;
          fetch  = 1'b1;
        end
      end
      hmap_pkg::ST_WR_BUSY: begin
        // Short write keeps the last sample
        if (!acc_wr_s) begin
          st_d = hmap_pkg::ST_WR_PUSH;
        end else if (min_ok && in_ready) begin
          st_d   = hmap_pkg::ST_WR_LONG;
          busy_d = 1'b0;
        end
      end
      hmap_pkg::ST_WR_PUSH: begin
        in_valid = min_ok;
        if (min_ok && in_ready) begin
          st_d   = hmap_pkg::ST_IDLE;
          busy_d = 1'b0;
          addr_d = addr_nx;
        end
      end
      hmap_pkg::ST_WR_LONG: begin
        // Long write commits at its end
        if (!acc_wr_s) begin
          in_valid = 1'b1;
          st_d     = hmap_pkg::ST_IDLE;
          addr_d   = addr_nx;
        end
      end
      hmap_pkg::ST_RD_BUSY: begin
        // Short read only mode holds acknowledge until the read ends; ordinary mode once the buffer is empty.
        if (!out_valid && (!short_read_only || !acc_rd_s)) begin
          st_d   = hmap_pkg::ST_RD_END;
          busy_d = 1'b0;
        end
      end
      hmap_pkg::ST_RD_END: begin
        // Word on the bus changes only once the read ended
        if (!acc_rd_s) begin
          st_d   = hmap_pkg::ST_IDLE;
          addr_d = addr_nx;
          fetch  = 1'b1;
        end
      end
      default: begin
        st_d   = hmap_pkg::ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
    prev_d = prev_q;
    if (fetch) begin
      prev_d = (addr_d == hmap_pkg::OVL_ADDR) ? ovl_q
             : mem_q[addr_d[hmap_pkg::MEM_AW-1:0]];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q   <= hmap_pkg::ST_IDLE;
      tm_q   <= hmap_pkg::CNT_ZERO;
      addr_q <= hmap_pkg::ADDR_ZERO;
      last_q <= hmap_pkg::DATA_ZERO;
      prev_q <= hmap_pkg::DATA_ZERO;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      tm_q   <= tm_d;
      addr_q <= addr_d;
      last_q <= last_d;
      prev_q <= prev_d;
      busy_q <= busy_d;
    end
  end

  // Busy from the pins, then the synchronised view, then the sequencer.
  // A strobe shorter than about one and a half clocks can still let acknowledge dip early.
  assign host_ack_n = busy_q | ((acc_raw | acc_wr_s | acc_rd_s) & ~taken);
  // Drive while the read lasts, release when it ends
  assign host_addr_data_bus_oe = acc_rd_raw;
  assign host_addr_data_bus_o  = prev_q;

  a_write_busy_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    st_q == hmap_pkg::ST_IDLE && acc_wr_s |=> host_ack_n [*2])
    else $error("write acknowledge released too early");
  a_write_busy_seen: assert property (@(posedge mclk) disable iff (sys_rst)
    st_q == hmap_pkg::ST_WR_BUSY |-> host_ack_n)
    else $error("acknowledge low during write busy");
  a_read_busy_seen: assert property (@(posedge mclk) disable iff (sys_rst)
    st_q == hmap_pkg::ST_IDLE && acc_rd_s |=> host_ack_n)
    else $error("acknowledge low at read start");
  a_short_write_push: assert property (@(posedge mclk) disable iff (sys_rst)
    st_q == hmap_pkg::ST_WR_BUSY && !acc_wr_s && in_ready |=> ##[0:2] in_valid && in_ready)
    else $error("short write not committed");
  a_long_write_data: assert property (@(posedge mclk) disable iff (sys_rst)
    st_q == hmap_pkg::ST_WR_LONG && !acc_wr_s |-> in_ready && in_word.data == $past(data_s))
    else $error("long write lost its word");
  a_read_word_stable: assert property (@(posedge mclk) disable iff (sys_rst)
    st_q != hmap_pkg::ST_IDLE && acc_rd_s |=> $stable(prev_q))
    else $error("read word changed during read");
  a_bus_release: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(acc_rd_s) && !acc_rd_raw |-> !host_addr_data_bus_oe)
    else $error("bus still driven after read");
  a_sro_core_set: assert property (@(posedge mclk) disable iff (sys_rst)
    core_ovl_we |=> short_read_only == $past(core_ovl_data[hmap_pkg::SRO_BIT]))
    else $error("short read only bit not written");
  a_sro_reset_off: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(sys_rst) |-> !short_read_only)
    else $error("short read only set after reset");
  a_sro_host_set: assert property (@(posedge mclk) disable iff (sys_rst)
    drain_ovl && !core_ovl_we |=> port_overlay_control == $past(out_word.data))
    else $error("host overlay write lost");

  c_long_write: cover property (@(posedge mclk) disable iff (sys_rst)
    st_q == hmap_pkg::ST_WR_LONG ##1 st_q == hmap_pkg::ST_IDLE);
  c_short_write: cover property (@(posedge mclk) disable iff (sys_rst)
    st_q == hmap_pkg::ST_WR_PUSH ##1 st_q == hmap_pkg::ST_IDLE);
  c_sro_read: cover property (@(posedge mclk) disable iff (sys_rst)
    short_read_only && st_q == hmap_pkg::ST_RD_END);
  c_buffer_full: cover property (@(posedge mclk) disable iff (sys_rst) !in_ready);
endmodule

/* File: hmap_host_model.sv */
// Host model that drives the port pins with short and long cycles.
// Assumes the testbench calls its tasks one at a time.
`timescale 1ns/1ps
module hmap_host_model (
  // Pins
  input  wire logic        mclk,
  input  wire logic        ack_n,
  input  wire logic [15:0] bus_o,
  input  wire logic        bus_oe,
  output logic             sel_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic [15:0]      bus_i
);
  logic [15:0] drv_q;
  int          n;
  // The wire carries the port's word while it drives, else the host's.
  assign bus_i = bus_oe ? bus_o : drv_q;
  initial begin
    sel_n = 1'b1;
    rd_n  = 1'b1;
    wr_n  = 1'b1;
    drv_q = 16'h0000;
  end
  // Start when idle.
  // Four clocks let the sequencer settle, since acknowledge falls before it idles.
  task automatic wait_ready();
    n = 0;
    repeat (4) @(negedge mclk);
    while (ack_n !== 1'b0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic wr(input logic [15:0] d, input bit lng, output logic ah, output realtime bt);
    realtime t0;
    wait_ready();
    t0    = $realtime;
    sel_n = 1'b0;
    wr_n  = 1'b0;
    drv_q = d;
    #5 ah = ack_n;
    bt = 0;
    if (lng) begin
      n = 0;
      while (ack_n !== 1'b0 && n < 200) begin
        #1 n++;
      end
      bt = $realtime - t0;
    end
    // Hold data past ready.
    // A short strobe spans two clocks so the synchronised view overlaps it.
    repeat (2) @(negedge mclk);
    sel_n = 1'b1;
    wr_n  = 1'b1;
    @(negedge mclk);
    drv_q = ~d;
  endtask
  // Data reads only; an ordinary read lasts one clock.
  task automatic rd(input int ncyc, output logic [15:0] d0, output logic [15:0] d1,
                    output logic on, output logic ah, output logic off);
    wait_ready();
    sel_n = 1'b0;
    rd_n  = 1'b0;
    #5 d0 = bus_i;
    on = bus_oe;
    ah = ack_n;
    repeat (ncyc) @(negedge mclk);
    d1    = bus_i;
    sel_n = 1'b1;
    rd_n  = 1'b1;
    #5 off = bus_oe;
    @(negedge mclk);
  endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the host memory access port.
// Assumes a 50 MHz clock and the host model for the pins.
`timescale 1ns/1ps
module tb_top;
  logic        mclk, sys_rst, sel_n, rd_n, wr_n, ack_n, oe, sro;
  logic        mem_busy, addr_we, ovl_we, ah, on, off;
  logic [15:0] bi, bo, ovl, ovl_d, d0, d1;
  logic [13:0] addr;
  logic [15:0] exp_q [5] = '{16'h1234, 16'ha5c3, 16'h0f0f, 16'hf0f0, 16'h5a5a};
  realtime     bt;
  int          n_mismatch, samples_checked;
  hmap_port uut (.mclk(mclk), .sys_rst(sys_rst), .host_select_n(sel_n),
    .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n), .host_ack_n(ack_n),
    .host_addr_data_bus_i(bi), .host_addr_data_bus_o(bo), .host_addr_data_bus_oe(oe),
    .core_mem_busy(mem_busy), .core_addr_we(addr_we), .core_addr(addr),
    .core_ovl_we(ovl_we), .core_ovl_data(ovl_d), .port_overlay_control(ovl),
    .short_read_only(sro));
  hmap_host_model host (.mclk(mclk), .ack_n(ack_n), .bus_o(bo), .bus_oe(oe),
    .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n), .bus_i(bi));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic core_load(input logic [13:0] a);
    repeat (4) @(negedge mclk);
    addr    = a;
    addr_we = 1'b1;
    @(negedge mclk);
    addr_we = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  task automatic core_ovl(input logic [15:0] d);
    ovl_d  = d;
    ovl_we = 1'b1;
    @(negedge mclk);
    ovl_we = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  // Host sets the mode bit, core clears it again.
  task automatic t_overlay();
    chk(ovl, 16'h0000);
    chk(16'(sro), 16'h0000);
    core_load(14'h3fe7);
    host.wr(16'h4000, 1'b0, ah, bt);
    repeat (10) @(negedge mclk);
    chk(ovl, 16'h4000);
    chk(16'(sro), 16'h0001);
    core_ovl(16'h0000);
    chk(16'(sro), 16'h0000);
  endtask
  // Short and long writes, then a stalled buffer refusing a third word.
  task automatic t_write();
    core_load(14'h0010);
    host.wr(exp_q[0], 1'b0, ah, bt);
    chk(16'(ah), 16'h0001);
    host.wr(exp_q[1], 1'b1, ah, bt);
    chk(16'(ah), 16'h0001);
    chk(16'(bt >= 30.0), 16'h0001);
    chk(16'(bt <= 120.0), 16'h0001);
    // Let the long write reach memory before the stall starts.
    repeat (4) @(negedge mclk);
    mem_busy = 1'b1;
    for (int i = 2; i < 5; i++) host.wr(exp_q[i], 1'b0, ah, bt);
    repeat (8) @(negedge mclk);
    chk(16'(ack_n), 16'h0001);
    mem_busy = 1'b0;
    repeat (10) @(negedge mclk);
    chk(16'(ack_n), 16'h0000);
  endtask
  // Reads back in ordinary mode, then in short read only mode.
  task automatic t_read();
    core_load(14'h0010);
    for (int i = 0; i < 5; i++) begin
      if (i == 3) core_ovl(16'h4000);
      host.rd((i < 3) ? 1 : 4, d0, d1, on, ah, off);
      chk(d0, exp_q[i]);
      chk(d1, exp_q[i]);
      chk(16'({on, ah, off}), 16'h0006);
    end
  endtask
  initial begin
    sys_rst  = 1'b1;
    mem_busy = 1'b0;
    addr_we  = 1'b0;
    ovl_we   = 1'b0;
    addr     = 14'h0000;
    ovl_d    = 16'h0000;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (3) @(negedge mclk);
    t_overlay();
    t_write();
    t_read();
    give_verdict();
  end
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
endmodule
